// >>> pbsp_core.v
`timescale 1ns/1ps
`include "pbsp_map.vh"

module pbsp_core #(
	parameter ADDR_W = `PBSP_ADDR_W,
	parameter LANES = `PBSP_LANES,
	parameter LANE_W = `PBSP_LANE_W
)
(
	input wire i_ref_clk,
	input wire i_rst,
	input wire [ADDR_W-1:0] i_address_inputs,
	input wire i_chip_select_first_n,
	input wire i_chip_select_second,
	input wire i_chip_select_third_n,
	input wire i_burst_advance_load_n,
	input wire i_write_enable_n,
	input wire [LANES-1:0] i_byte_lane_strobe_n,
	input wire i_clock_enable_n,
	input wire i_output_enable_n,
	input wire i_burst_order_select,
	input wire i_sleep_request,
	input wire [LANES*LANE_W-1:0] i_data,
	output reg [LANES*LANE_W-1:0] o_data,
	output reg o_data_oe_n,
	output reg o_sleep_state
);

	localparam DATA_W = LANES * LANE_W;
	localparam HI_W = ADDR_W - `PBSP_BEAT_W;

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	reg oe_meta;
	reg oe_q;
	reg order_meta;
	reg order_q;
	reg sleep_meta;
	reg sleep_q;

	reg [`PBSP_PWR_W-1:0] pwr_state;
	reg [`PBSP_PWR_W-1:0] next_pwr_state;
	reg [`PBSP_CNT_W-1:0] pwr_cnt;
	reg [`PBSP_CNT_W-1:0] next_pwr_cnt;

	reg burst_act;
	reg burst_wr;
	reg [HI_W-1:0] burst_hi;
	reg [`PBSP_BEAT_W-1:0] burst_base;
	reg [`PBSP_BEAT_W-1:0] burst_beat;

	reg s1_rd;
	reg s1_wr;
	reg [ADDR_W-1:0] s1_addr;
	reg [LANES-1:0] s1_lane_en;
	reg s2_wr;
	reg [ADDR_W-1:0] s2_addr;
	reg [LANES-1:0] s2_lane_en;
	reg data_valid;

	reg [`PBSP_BEAT_W-1:0] next_low;
	reg next_data_valid;

	wire chip_active;
	wire run;
	wire go;
	wire load;
	wire cont;
	wire new_rd;
	wire new_wr;
	wire cont_op;
	wire op_rd;
	wire op_wr;
	wire [`PBSP_BEAT_W-1:0] next_beat;
	wire [ADDR_W-1:0] op_addr;
	wire mem_wr_en;
	wire [DATA_W-1:0] mem_rd_data;

	// ------------------------------------------------------------------------
	// Pin synchronisers for the inputs that act without the clock
	// ------------------------------------------------------------------------

	// Two flops each; only the second one is read by logic
	always @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			oe_meta <= 1'b1;
			oe_q <= 1'b1;
			order_meta <= `PBSP_ORDER_LINEAR;
			order_q <= `PBSP_ORDER_LINEAR;
			sleep_meta <= 1'b0;
			sleep_q <= 1'b0;
		end
		else
		begin
			oe_meta <= i_output_enable_n;
			oe_q <= oe_meta;
			order_meta <= i_burst_order_select;
			order_q <= order_meta;
			sleep_meta <= i_sleep_request;
			sleep_q <= sleep_meta;
		end
	end

	// ------------------------------------------------------------------------
	// Power sequencing: run, entering sleep, asleep, waking
	// ------------------------------------------------------------------------

	// Next power state and its cycle counter
	always @*
	begin
		next_pwr_state = pwr_state;
		next_pwr_cnt = pwr_cnt;
		case (pwr_state)
			`PBSP_PWR_RUN:
			begin
				if (sleep_q)
				begin
					next_pwr_state = `PBSP_PWR_ENTER;
					next_pwr_cnt = `PBSP_CNT_ZERO;
				end
			end
			`PBSP_PWR_ENTER:
			begin
				if (!sleep_q)
				begin
					next_pwr_state = `PBSP_PWR_RUN;
				end
				else if (pwr_cnt == `PBSP_SLEEP_CYC - `PBSP_CNT_STEP)
				begin
					next_pwr_state = `PBSP_PWR_SLEEP;
				end
				else
				begin
					next_pwr_cnt = pwr_cnt + `PBSP_CNT_STEP;
				end
			end
			`PBSP_PWR_SLEEP:
			begin
				if (!sleep_q)
				begin
					next_pwr_state = `PBSP_PWR_WAKE;
					next_pwr_cnt = `PBSP_CNT_ZERO;
				end
			end
			`PBSP_PWR_WAKE:
			begin
				if (sleep_q)
				begin
					next_pwr_state = `PBSP_PWR_SLEEP;
				end
				else if (pwr_cnt == `PBSP_WAKE_CYC - `PBSP_CNT_STEP)
				begin
					next_pwr_state = `PBSP_PWR_RUN;
				end
				else
				begin
					next_pwr_cnt = pwr_cnt + `PBSP_CNT_STEP;
				end
			end
			default:
			begin
				next_pwr_state = `PBSP_PWR_RUN;
				next_pwr_cnt = `PBSP_CNT_ZERO;
			end
		endcase
	end

	// Power state registers and the sleep indicator
	always @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			pwr_state <= `PBSP_PWR_RUN;
			pwr_cnt <= `PBSP_CNT_ZERO;
			o_sleep_state <= 1'b0;
		end
		else
		begin
			pwr_state <= next_pwr_state;
			pwr_cnt <= next_pwr_cnt;
			o_sleep_state <= (next_pwr_state == `PBSP_PWR_SLEEP);
		end
	end

	// ------------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------------

	// Operations are taken while running or before sleep has set in
	assign run = (pwr_state == `PBSP_PWR_RUN) || (pwr_state == `PBSP_PWR_ENTER);
	assign go = run && !i_clock_enable_n;
	assign chip_active = !i_chip_select_first_n && i_chip_select_second && !i_chip_select_third_n;
	assign load = go && !i_burst_advance_load_n;
	assign cont = go && i_burst_advance_load_n;
	assign new_rd = load && chip_active && i_write_enable_n;
	assign new_wr = load && chip_active && !i_write_enable_n;
	assign cont_op = cont && burst_act;
	assign op_rd = new_rd || (cont_op && !burst_wr);
	assign op_wr = new_wr || (cont_op && burst_wr);

	// ------------------------------------------------------------------------
	// Burst address generation
	// ------------------------------------------------------------------------

	// Beat count wraps in two bits, so the fifth beat is the start again
	assign next_beat = burst_beat + `PBSP_BEAT_STEP;

	// Low address bits of the next beat in the strapped order
	always @*
	begin
		next_low = burst_base;
		if (order_q == `PBSP_ORDER_INTERLEAVE)
		begin
			next_low = burst_base ^ next_beat;
		end
		else
		begin
			next_low = burst_base + next_beat;
		end
	end

	assign op_addr = load ? i_address_inputs : {burst_hi, next_low};

	// Burst context: loaded on advance low, stepped on advance high
	always @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			burst_act <= 1'b0;
			burst_wr <= 1'b0;
			burst_hi <= {HI_W{1'b0}};
			burst_base <= `PBSP_BEAT_FIRST;
			burst_beat <= `PBSP_BEAT_FIRST;
		end
		else if (load)
		begin
			burst_act <= chip_active;
			burst_wr <= !i_write_enable_n;
			burst_hi <= i_address_inputs[ADDR_W-1:`PBSP_BEAT_W];
			burst_base <= i_address_inputs[`PBSP_BURST_MSB:`PBSP_BURST_LSB];
			burst_beat <= `PBSP_BEAT_FIRST;
		end
		else if (cont_op)
		begin
			burst_beat <= next_beat;
		end
	end

	// ------------------------------------------------------------------------
	// Pipeline: address stage, then late write stage
	// ------------------------------------------------------------------------

	// Every stage holds while the clock enable is high or the part sleeps or is waking
	always @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			s1_rd <= 1'b0;
			s1_wr <= 1'b0;
			s1_addr <= {ADDR_W{1'b0}};
			s1_lane_en <= `PBSP_LANE_OFF;
			s2_wr <= 1'b0;
			s2_addr <= {ADDR_W{1'b0}};
			s2_lane_en <= `PBSP_LANE_OFF;
			data_valid <= 1'b0;
		end
		else if (go)
		begin
			s1_rd <= op_rd;
			s1_wr <= op_wr;
			s1_addr <= op_addr;
			s1_lane_en <= op_wr ? ~i_byte_lane_strobe_n : `PBSP_LANE_OFF;
			s2_wr <= s1_wr;
			s2_addr <= s1_addr;
			s2_lane_en <= s1_lane_en;
			data_valid <= next_data_valid;
		end
	end

	// Write lands at the second edge after its command, with that edge's data
	assign mem_wr_en = go && s2_wr && (s2_lane_en != `PBSP_LANE_OFF);

	// ------------------------------------------------------------------------
	// Storage array
	// ------------------------------------------------------------------------

	// Read is launched on the command edge, so data sits ready one edge later
	pbsp_mem #(
		.ADDR_W(ADDR_W),
		.LANES(LANES),
		.LANE_W(LANE_W)
	) u_mem (
		.i_ref_clk(i_ref_clk),
		.i_rd_en(go && op_rd),
		.i_rd_addr(op_addr),
		.o_rd_data(mem_rd_data),
		.i_wr_en(mem_wr_en),
		.i_wr_addr(s2_addr),
		.i_wr_lane_en(s2_lane_en),
		.i_wr_data(i_data)
	);

	// ------------------------------------------------------------------------
	// Output register and drivers
	// ------------------------------------------------------------------------

	// Read beat valid on the output after the next accepted edge
	always @*
	begin
		next_data_valid = data_valid;
		if (go)
		begin
			next_data_valid = s1_rd;
		end
	end

	// Data register loads on the edge after the read; drivers follow enable
	always @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_data <= `PBSP_DATA_RST;
			o_data_oe_n <= 1'b1;
		end
		else
		begin
			if (go && s1_rd)
			begin
				o_data <= mem_rd_data;
			end
			o_data_oe_n <= !next_data_valid || oe_q;
		end
	end

endmodule // pbsp_core

// >>> pbsp_map.vh
`ifndef PBSP_MAP_VH
`define PBSP_MAP_VH

// ----------------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------------
`define PBSP_ADDR_W 20
`define PBSP_LANES 4
`define PBSP_LANE_W 9
`define PBSP_DATA_W 36

// ----------------------------------------------------------------------------
// Burst address field
// ----------------------------------------------------------------------------
`define PBSP_BURST_MSB 1
`define PBSP_BURST_LSB 0
`define PBSP_BEAT_W 2
`define PBSP_BEAT_FIRST 2'h0
`define PBSP_BEAT_STEP 2'h1
`define PBSP_ORDER_LINEAR 1'h0
`define PBSP_ORDER_INTERLEAVE 1'h1

// ----------------------------------------------------------------------------
// Power sequencing
// ----------------------------------------------------------------------------
`define PBSP_PWR_W 2
`define PBSP_PWR_RUN 2'h0
`define PBSP_PWR_ENTER 2'h1
`define PBSP_PWR_SLEEP 2'h2
`define PBSP_PWR_WAKE 2'h3
`define PBSP_CNT_W 2
`define PBSP_CNT_ZERO 2'h0
`define PBSP_CNT_STEP 2'h1
`define PBSP_SLEEP_CYC 2'h2
`define PBSP_WAKE_CYC 2'h2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PBSP_DATA_RST 36'h0_0000_0000
`define PBSP_LANE_OFF 4'h0

`endif

// >>> pbsp_mem.v
`timescale 1ns/1ps
`include "pbsp_map.vh"

module pbsp_mem #(
	parameter ADDR_W = `PBSP_ADDR_W,
	parameter LANES = `PBSP_LANES,
	parameter LANE_W = `PBSP_LANE_W
)
(
	input wire i_ref_clk,
	input wire i_rd_en,
	input wire [ADDR_W-1:0] i_rd_addr,
	output wire [LANES*LANE_W-1:0] o_rd_data,
	input wire i_wr_en,
	input wire [ADDR_W-1:0] i_wr_addr,
	input wire [LANES-1:0] i_wr_lane_en,
	input wire [LANES*LANE_W-1:0] i_wr_data
);

	localparam DEPTH = 1 << ADDR_W;

	// ------------------------------------------------------------------------
	// One storage column per byte lane (eight data bits and one parity bit)
	// ------------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < LANES; g = g + 1)
		begin : lane
			reg [LANE_W-1:0] ram [0:DEPTH-1];
			reg [LANE_W-1:0] rd_q;

			// Lane write on its own strobe, read into the lane output register
			always @(posedge i_ref_clk)
			begin
				if (i_wr_en && i_wr_lane_en[g])
				begin
					ram[i_wr_addr] <= i_wr_data[g*LANE_W +: LANE_W];
				end
				if (i_rd_en)
				begin
					rd_q <= ram[i_rd_addr];
				end
			end

			assign o_rd_data[g*LANE_W +: LANE_W] = rd_q;
		end
	endgenerate

endmodule // pbsp_mem

// >>> pbsp_ctrl_model.sv
`timescale 1ns/1ps
module pbsp_ctrl_model (
	input wire i_ref_clk,
	input wire i_clock_enable_n,
	input wire i_wr_beat,
	input wire [35:0] i_wr_word,
	output wire [35:0] o_data
);
	reg [36:0] stage1 = 37'h0;
	reg [36:0] stage2 = 37'h0;
	reg [35:0] last = 36'h0;
	// Write data trails its command by two accepted edges
	always @(posedge i_ref_clk)
		if (!i_clock_enable_n)
		begin
			stage1 <= {i_wr_beat, i_wr_word};
			stage2 <= stage1;
			last <= stage2[35:0];
		end
	// A released bus shows the inverse of the last word, never a stale copy
	assign o_data = stage2[36] ? stage2[35:0] : ~last;
endmodule  // pbsp_ctrl_model

// >>> pbsp_core_sva.sv
`timescale 1ns/1ps
module pbsp_core_sva #(
	parameter ADDR_W = 20,
	parameter LANES = 4,
	parameter LANE_W = 9
)
(
	input wire i_ref_clk,
	input wire i_rst,
	input wire [ADDR_W-1:0] i_address_inputs,
	input wire i_chip_select_first_n,
	input wire i_chip_select_second,
	input wire i_chip_select_third_n,
	input wire i_burst_advance_load_n,
	input wire i_write_enable_n,
	input wire [LANES-1:0] i_byte_lane_strobe_n,
	input wire i_clock_enable_n,
	input wire i_output_enable_n,
	input wire i_burst_order_select,
	input wire i_sleep_request,
	input wire [LANES*LANE_W-1:0] i_data,
	input wire [LANES*LANE_W-1:0] o_data,
	input wire o_data_oe_n,
	input wire o_sleep_state
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	// Command decode at the sampling edge
	wire on = !i_chip_select_first_n && i_chip_select_second && !i_chip_select_third_n;
	wire load = !i_clock_enable_n && !i_burst_advance_load_n;
	wire calm = !i_clock_enable_n && !i_sleep_request;
	property p_reset;
		$fell(i_rst) |-> o_data == '0 && o_data_oe_n && !o_sleep_state;
	endproperty
	a_reset: assert property (p_reset) else $error("bad values after reset");
	property p_frozen;
		i_clock_enable_n && ($past(i_output_enable_n, 2) == $past(i_output_enable_n, 3)) |=> $stable(o_data) && $stable(o_data_oe_n);
	endproperty
	a_frozen: assert property (p_frozen) else $error("outputs moved while suspended");
	property p_read_on;
		(calm && !i_output_enable_n)[*6] ##0 (load && on && i_write_enable_n) ##1 !i_clock_enable_n |=> !o_data_oe_n;
	endproperty
	a_read_on: assert property (p_read_on) else $error("read data not driven");
	property p_quiet;
		calm[*6] ##0 (load && !(on && i_write_enable_n)) ##1 !i_clock_enable_n |=> o_data_oe_n;
	endproperty
	a_quiet: assert property (p_quiet) else $error("bus driven after write or deselect");
	property p_oe_off;
		(calm && i_output_enable_n)[*6] |=> o_data_oe_n;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("bus driven with output enable high");
	property p_sleep_late;
		$rose(i_sleep_request) |-> (!o_sleep_state)[*3];
	endproperty
	a_sleep_late: assert property (p_sleep_late) else $error("sleep entered too early");
	property p_sleep_in;
		i_sleep_request[*8] |-> o_sleep_state;
	endproperty
	a_sleep_in: assert property (p_sleep_in) else $error("sleep not entered");
	property p_wake;
		!i_sleep_request[*8] |-> !o_sleep_state;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake from sleep");
	property p_sleep_hold;
		o_sleep_state |=> $stable(o_data);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("data moved in sleep");
endmodule  // pbsp_core_sva
bind pbsp_core pbsp_core_sva #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) u_pbsp_core_sva (.*);

// >>> pbsp_core_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module pbsp_core_bench;
	reg clk = 0;
	reg rst = 1;
	reg [5:0] addr = 6'h0;
	reg cs_a_n = 0, cs_b = 1, cs_c_n = 0, ld_n = 1, we_n = 1, cke_n = 0, oe_n = 0;
	reg ord = 0, slp = 0, wbeat = 0, pend = 0, rdb = 0;
	reg [3:0] strb_n = 4'hF;
	reg [35:0] wword = 36'h0, pexp = 36'h0;
	reg [36:0] held;
	reg [35:0] mem [0:63];
	wire [35:0] din, dout;
	wire doe_n, sstate;
	integer error_cnt = 0, num_checks = 0, i, j, k;
	// Clock and watchdog
	initial
		forever #5 clk = ~clk;
	initial
	begin
		#20000;
		error_cnt++;
		give_verdict;
	end
	pbsp_core #(.ADDR_W(6)) u_pbsp_core (
		.i_ref_clk(clk),
		.i_rst(rst),
		.i_address_inputs(addr),
		.i_chip_select_first_n(cs_a_n),
		.i_chip_select_second(cs_b),
		.i_chip_select_third_n(cs_c_n),
		.i_burst_advance_load_n(ld_n),
		.i_write_enable_n(we_n),
		.i_byte_lane_strobe_n(strb_n),
		.i_clock_enable_n(cke_n),
		.i_output_enable_n(oe_n),
		.i_burst_order_select(ord),
		.i_sleep_request(slp),
		.i_data(din),
		.o_data(dout),
		.o_data_oe_n(doe_n),
		.o_sleep_state(sstate)
	);
	pbsp_ctrl_model u_pbsp_ctrl_model (
		.i_ref_clk(clk),
		.i_clock_enable_n(cke_n),
		.i_wr_beat(wbeat),
		.i_wr_word(wword),
		.o_data(din)
	);
	// Burst address and data pattern
	function [5:0] nb(input [5:0] b, input [1:0] n);
		nb = {b[5:2], ord ? b[1:0] ^ n : b[1:0] + n};
	endfunction
	function [35:0] pat(input [5:0] a);
		pat = {3{a, ~a}};
	endfunction
	// One command beat; checks the read issued one beat earlier
	task op(input l, input w, input [3:0] s, input [5:0] a, input [35:0] d);
		begin
			ld_n = l;
			we_n = w;
			strb_n = s;
			addr = a;
			wbeat = !w;
			wword = d;
			for (k = 0; k < 4; k++)
				if (!w && !s[k])
					mem[a][9*k+:9] = d[9*k+:9];
			@(posedge clk);
			#1;
			if (pend)
				`CHK({doe_n, dout}, {1'b0, pexp})
			if (!l)
				rdb = w && !cs_a_n && cs_b && !cs_c_n;
			pend = rdb && !oe_n;
			pexp = mem[a];
		end
	endtask
	task burst(input w, input [3:0] s, input [5:0] b, input [35:0] x);
		for (j = 0; j < 4; j++)
			op(j != 0, w, s, nb(b, j), pat(nb(b, j)) ^ x);
	endtask
	task give_verdict;
		begin
			$display("checks=%0d errors=%0d", num_checks, error_cnt);
			if (error_cnt == 0 && num_checks > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk);
		#1;
		rst = 0;
		`CHK({doe_n, dout, sstate}, {1'b1, 36'h0, 1'b0})
		burst(0, 4'h0, 6'h02, 36'h0);
		burst(0, 4'h0, 6'h10, 36'hF_FFFF_FFFF);
		for (i = 0; i < 4; i++)
			op(0, 0, ~(4'h1 << i), 6'h10 + i, pat(6'h10 + i));
		op(1, 0, 4'hF, 6'h10, 36'h0);
		burst(1, 4'hF, 6'h02, 36'h0);
		burst(1, 4'hF, 6'h12, 36'h0);
		op(0, 0, 4'h0, 6'h20, pat(6'h20));
		op(0, 1, 4'hF, 6'h13, 36'h0);
		for (i = 0; i < 3; i++)
		begin
			{cs_c_n, cs_b, cs_a_n} = 3'b010 ^ (3'b001 << i);
			op(0, 1, 4'hF, 6'h02, 36'h0);
			{cs_c_n, cs_b, cs_a_n} = 3'b010;
			op(1, 1, 4'hF, 6'h03, 36'h0);
			`CHK(doe_n, 1'b1)
		end
		ord = 1;
		repeat (6) op(1, 1, 4'hF, 6'h00, 36'h0);
		`CHK(doe_n, 1'b1)
		burst(1, 4'hF, 6'h11, 36'h0);
		op(0, 1, 4'hF, 6'h02, 36'h0);
		held = {doe_n, dout};
		cke_n = 1;
		ld_n = 0;
		addr = 6'h28;
		repeat (3) @(posedge clk);
		#1;
		`CHK({doe_n, dout}, held)
		cke_n = 0;
		for (i = 1; i < 4; i++)
			op(1, 1, 4'hF, nb(6'h02, i), 36'h0);
		oe_n = 1;
		repeat (6) op(0, 1, 4'hF, 6'h02, 36'h0);
		`CHK(doe_n, 1'b1)
		oe_n = 0;
		cs_b = 0;
		op(0, 1, 4'hF, 6'h00, 36'h0);
		cs_b = 1;
		slp = 1;
		repeat (8) op(1, 1, 4'hF, 6'h00, 36'h0);
		`CHK(sstate, 1'b1)
		slp = 0;
		repeat (8) op(1, 1, 4'hF, 6'h00, 36'h0);
		`CHK(sstate, 1'b0)
		burst(1, 4'hF, 6'h02, 36'h0);
		op(0, 1, 4'hF, 6'h20, 36'h0);
		op(1, 1, 4'hF, 6'h21, 36'h0);
		give_verdict;
	end
endmodule  // pbsp_core_bench
